// file: rtl/sar_adc_defines.svh
// constants for the successive-approximation converter control block
// What this block does
// - read/convert falling with select low starts conversion
// - read/convert rising with select low drives outputs
// - select falling with read/convert low starts conversion
// - select falling with read/convert high enables read
// - outputs released when select high or read/convert low
// - half-swap select exchanges upper and lower byte lanes
// - busy stays low for the whole conversion
// - result valid in latches when busy rises
// - both inputs low at busy rise restarts
// - approximation register cleared before first bit decision
// - start requests ignored while a conversion runs
// - bits resolved one at a time, top down
// - whole approximation register copied into output latches
// - result presented in two's complement form
// - internal clock gives about 2.0 us conversion
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define CONV_TIME_NS 2300
`define STEP_COUNT 18
`define TICK_CYCLES ((`CONV_TIME_NS) / ((`CLK_PERIOD_NS) * (`STEP_COUNT)))
`define ACQ_TIME_NS 1500
`define ACQ_CYCLES ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// data layout and reset values
// ----------------------------------------
`define RESULT_WIDTH 16
`define FIFO_DEPTH 16
`define MSB_INDEX 4'hf
`define MSB_TRIAL 16'h8000
`define SIGN_FLIP 16'h8000
`define LATCH_RESET 16'h0000
`define HALF_LO 7
`define HALF_HI 8

`endif

// file: rtl/sar_adc_pkg.sv
// types shared by the converter control block
package sar_adc_pkg;

   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_CLEAR,
      CONV_DECIDE,
      CONV_LOAD
   } conv_state_type;

   typedef struct packed {
      logic cs_n;
      logic rd_conv;
      logic half_swap;
   } host_pins_type;

   typedef struct packed {
      logic [15:0] data;
      logic oe_n;
   } bus_drive_type;

endpackage : sar_adc_pkg

// file: rtl/fall_detect.sv
// falling edge detector for one synchronous input
`timescale 1ns/1ps
module fall_detect (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // level in, pulse out
   input wire logic level,
   output logic fell
);
   typedef struct packed {
      logic prev;
   } fall_state_type;

   fall_state_type st;
   fall_state_type next_st;

   always_comb begin
      next_st = st;
      next_st.prev = level;
   end

   // idle level of the host strobes is high, so reset there
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st <= '{prev: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   assign fell = st.prev & ~level;

endmodule : fall_detect

// file: rtl/result_fifo.sv
// result word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } fifo_state_type;

   fifo_state_type st;
   fifo_state_type next_st;
   logic push;
   logic pop;

   assign in_ready = (st.count != (AW + 1)'(DEPTH));
   assign out_valid = (st.count != '0);
   assign out_data = st.mem[st.rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr_ptr] = in_data;
         next_st.wr_ptr = st.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
      next_st.count = st.count + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : result_fifo

// file: rtl/sar_adc_control.sv
// conversion sequencer and parallel readout of the converter
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
module sar_adc_control (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // host control pins
   input wire sar_adc_pkg::host_pins_type host,
   // analog front end
   input wire logic comp_keep,
   output logic [15:0] dac_trial,
   // three-state result port and status
   output logic [15:0] result_out_bus,
   output logic result_out_oe_n,
   output logic busy_n,
   // result stream
   output logic [15:0] stream_data,
   output logic stream_valid,
   input wire logic stream_ready
);
   import sar_adc_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      conv_state_type state;
      logic [15:0] approximation_register;
      logic [15:0] trial;
      logic [3:0] bit_idx;
      logic [1:0] tick_cnt;
      logic [15:0] latch;
      logic busy_n;
      bus_drive_type drive;
   } ctrl_state_type;

   localparam ctrl_state_type CTRL_RESET = '{
      state: CONV_IDLE,
      approximation_register: 16'h0000,
      trial: 16'h0000,
      bit_idx: 4'h0,
      tick_cnt: 2'h0,
      latch: `LATCH_RESET,
      busy_n: 1'b1,
      drive: '{data: 16'h0000, oe_n: 1'b1}
   };

   ctrl_state_type st;
   ctrl_state_type next_st;

   logic cs_fell;
   logic rd_fell;
   logic start_req;
   logic tick;
   logic gate_low;
   logic push_valid;
   logic push_ready;
   logic [15:0] result_word;

   // ----------------------------------------
   // start detection
   // ----------------------------------------
   fall_detect u_cs_fall (
      .sys_clk(sys_clk),
      .srst(srst),
      .level(host.cs_n),
      .fell(cs_fell)
   );

   fall_detect u_rd_fall (
      .sys_clk(sys_clk),
      .srst(srst),
      .level(host.rd_conv),
      .fell(rd_fell)
   );

   // the two strobes act as one ORed start gate
   assign start_req = (rd_fell & ~host.cs_n)
                    | (cs_fell & ~host.rd_conv);
   assign gate_low = ~(host.cs_n | host.rd_conv);

   // ----------------------------------------
   // internal conversion clock
   // ----------------------------------------
   // one decision tick every TICK_CYCLES system cycles
   assign tick = (st.tick_cnt == 2'(`TICK_CYCLES - 1));

   // offset-binary register flipped to signed output
   assign result_word = st.approximation_register ^ `SIGN_FLIP;

   // ----------------------------------------
   // result buffer
   // ----------------------------------------
   assign push_valid = (st.state == CONV_LOAD);

   result_fifo #(
      .WIDTH(`RESULT_WIDTH),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .srst(srst),
      .in_data(result_word),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .out_data(stream_data),
      .out_valid(stream_valid),
      .out_ready(stream_ready)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      // drivers on only with select low and read/convert high
      next_st.drive.oe_n = host.cs_n | ~host.rd_conv;
      if (host.half_swap) begin
         next_st.drive.data = {st.latch[`HALF_LO:0], st.latch[15:`HALF_HI]};
      end else begin
         next_st.drive.data = st.latch;
      end
      unique case (st.state)
         CONV_IDLE: begin
            if (start_req) begin
               next_st.state = CONV_CLEAR;
               next_st.busy_n = 1'b0;
            end
         end
         CONV_CLEAR: begin
            // a start in this or any later step is simply not looked at
            next_st.approximation_register = 16'h0000;
            next_st.trial = `MSB_TRIAL;
            next_st.bit_idx = `MSB_INDEX;
            next_st.tick_cnt = 2'h0;
            next_st.busy_n = 1'b0;
            next_st.state = CONV_DECIDE;
         end
         CONV_DECIDE: begin
            if (tick) begin
               next_st.tick_cnt = 2'h0;
               next_st.approximation_register[st.bit_idx] = comp_keep;
               if (st.bit_idx == 4'h0) begin
                  next_st.state = CONV_LOAD;
               end else begin
                  next_st.bit_idx = st.bit_idx - 4'h1;
                  next_st.trial = next_st.approximation_register
                                | (16'h0001 << (st.bit_idx - 4'h1));
               end
            end else begin
               next_st.tick_cnt = st.tick_cnt + 2'h1;
            end
         end
         CONV_LOAD: begin
            // a full buffer holds busy low until the drain side catches up
            if (push_ready) begin
               next_st.latch = result_word;
               next_st.busy_n = 1'b1;
               next_st.trial = 16'h0000;
               if (gate_low) begin
                  next_st.state = CONV_CLEAR;
               end else begin
                  next_st.state = CONV_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st <= CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign dac_trial = st.trial;
   assign result_out_bus = st.drive.data;
   assign result_out_oe_n = st.drive.oe_n;
   assign busy_n = st.busy_n;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   sequence s_conv_begin;
      (st.state == CONV_IDLE) && start_req;
   endsequence

   sequence s_busy_rise;
      $rose(busy_n);
   endsequence

   property p_start_busy;
      s_conv_begin |=> !busy_n ##1 (st.state == CONV_DECIDE);
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("start request did not begin a conversion");

   property p_cs_start;
      (st.state == CONV_IDLE) && cs_fell && !host.rd_conv |=> (st.state == CONV_CLEAR);
   endproperty
   a_cs_start: assert property (p_cs_start)
      else $error("select falling with read/convert low did not start");

   property p_hiz;
      (host.cs_n || !host.rd_conv) |=> result_out_oe_n;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("result port driven while it should be released");

   property p_drive;
      (!host.cs_n && host.rd_conv) |=> !result_out_oe_n;
   endproperty
   a_drive: assert property (p_drive)
      else $error("result port not driven during a read");

   property p_swap;
      host.half_swap |=> result_out_bus == {$past(st.latch[7:0]), $past(st.latch[15:8])};
   endproperty
   a_swap: assert property (p_swap)
      else $error("byte lanes not exchanged");

   property p_busy_hold;
      $fell(busy_n) |-> !busy_n [*8];
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("busy released too early");

   property p_result_valid;
      s_busy_rise |-> st.latch == ($past(st.approximation_register) ^ 16'h8000);
   endproperty
   a_result_valid: assert property (p_result_valid)
      else $error("latch not holding the new result at busy rise");

   property p_clear;
      (st.state == CONV_CLEAR) |=> (st.approximation_register == 16'h0000)
         && (st.bit_idx == 4'hf);
   endproperty
   a_clear: assert property (p_clear)
      else $error("approximation register not cleared at start");

   property p_no_restart;
      (st.state == CONV_DECIDE) |=> (st.state != CONV_CLEAR) && !busy_n;
   endproperty
   a_no_restart: assert property (p_no_restart)
      else $error("running conversion was restarted");

   property p_bit_order;
      (st.state == CONV_DECIDE) && tick && (st.bit_idx != 4'h0)
         |=> st.bit_idx == $past(st.bit_idx) - 4'h1;
   endproperty
   a_bit_order: assert property (p_bit_order)
      else $error("bit index did not step down by one");

   property p_restart;
      (st.state == CONV_LOAD) && push_ready && gate_low
         |=> busy_n ##1 !busy_n;
   endproperty
   a_restart: assert property (p_restart)
      else $error("no back-to-back conversion with both strobes low");

   property p_latch_hold;
      busy_n && $past(busy_n) |-> $stable(st.latch);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latch changed between conversions");

   // clear step, then sixteen decisions of one tick period each
   localparam int DECIDE_SPAN = `RESULT_WIDTH * `TICK_CYCLES + 1;

   sequence s_decisions_done;
      ##DECIDE_SPAN (st.state == CONV_LOAD);
   endsequence

   property p_conv_span;
      (st.state == CONV_CLEAR) |-> s_decisions_done;
   endproperty
   a_conv_span: assert property (p_conv_span)
      else $error("conversion did not take sixteen decision periods");

   property p_first_trial;
      (st.state == CONV_CLEAR) |=> (dac_trial == `MSB_TRIAL);
   endproperty
   a_first_trial: assert property (p_first_trial)
      else $error("first trial is not the top bit");

   property p_load_copy;
      (st.state == CONV_LOAD) && push_ready |=> (st.latch == $past(result_word)) && stream_valid;
   endproperty
   a_load_copy: assert property (p_load_copy)
      else $error("finished result not copied out");

   property p_stall_busy;
      (st.state == CONV_LOAD) && !push_ready |=> !busy_n && (st.state == CONV_LOAD);
   endproperty
   a_stall_busy: assert property (p_stall_busy)
      else $error("busy released while the result could not be stored");

endmodule : sar_adc_control

// file: verification/comp_model.sv
// comparator stand-in that judges each trial code against a held input code
`timescale 1ns/1ps
module comp_model (
   // trial code from the sequencer
   input wire logic [15:0] dac_trial,
   // held input as an offset-binary code
   input wire logic [15:0] vin_code,
   // decision back to the sequencer
   output logic comp_keep
);
   // keep while the trial does not exceed the input, so the register settles on vin_code
   assign comp_keep = (dac_trial <= vin_code);
endmodule : comp_model

// file: verification/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin fails++; \
   $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module tb_top;
   import sar_adc_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   host_pins_type host = '{cs_n: 1'b1, rd_conv: 1'b1, half_swap: 1'b0};
   logic stream_ready = 1'b0;
   logic [15:0] vin_code = 16'h0000;
   logic [15:0] last = 16'h0000;
   logic comp_keep, result_out_oe_n, busy_n, stream_valid;
   logic [15:0] dac_trial, result_out_bus, stream_data;
   int fails = 0;
   int compares = 0;

   always #20 sys_clk = ~sys_clk;

   sar_adc_control dut (.sys_clk(sys_clk), .srst(srst), .host(host), .comp_keep(comp_keep),
      .dac_trial(dac_trial), .result_out_bus(result_out_bus),
      .result_out_oe_n(result_out_oe_n), .busy_n(busy_n), .stream_data(stream_data),
      .stream_valid(stream_valid), .stream_ready(stream_ready));
   comp_model comp (.dac_trial(dac_trial), .vin_code(vin_code), .comp_keep(comp_keep));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // inputs always move 1 ns after the rising edge
   task automatic step(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step

   task automatic wait_busy(input logic lvl);
      int i;
      for (i = 0; i < 300 && busy_n !== lvl; i++) step();
      `CHK("busy_n", lvl, busy_n)
   endtask : wait_busy

   function automatic logic [15:0] lanes(input logic [15:0] w, input logic swap);
      return swap ? {w[7:0], w[15:8]} : w;
   endfunction : lanes

   // enable and data are registered, so look two edges after the pins move
   task automatic read_check(input logic [15:0] res);
      step(2);
      `CHK("result_out_oe_n", 1'b0, result_out_oe_n)
      `CHK("result_out_bus", lanes(res, host.half_swap), result_out_bus)
   endtask : read_check

   task automatic pop_check(input logic [15:0] res);
      int i;
      for (i = 0; i < 300 && stream_valid !== 1'b1; i++) step();
      `CHK("stream_data", res, stream_data)
      stream_ready = 1'b1;
      step();
      stream_ready = 1'b0;
      step();
   endtask : pop_check

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      `CHK("busy_n", 1'b1, busy_n)
      `CHK("result_out_oe_n", 1'b1, result_out_oe_n)
      `CHK("stream_valid", 1'b0, stream_valid)
      `CHK("result_out_bus", `LATCH_RESET, result_out_bus)
      $display("test reset done");
   endtask : t_reset

   task automatic t_rc_mode(input logic [15:0] v, input logic swap);
      int n;
      step(`ACQ_CYCLES);
      vin_code = v;
      host.half_swap = swap;
      host.cs_n = 1'b0;
      step(2);
      host.rd_conv = 1'b0;
      step(2);
      `CHK("result_out_oe_n", 1'b1, result_out_oe_n)
      `CHK("dac_trial", `MSB_TRIAL, dac_trial)
      wait_busy(1'b0);
      // strobe back high well inside the settling limit
      host.rd_conv = 1'b1;
      read_check(last);
      n = 0;
      while (busy_n === 1'b0 && n < 300) begin
         n++;
         step();
      end
      `CHK("busy low span", 1'b1, n >= 44)
      read_check(v ^ `SIGN_FLIP);
      pop_check(v ^ `SIGN_FLIP);
      last = v ^ `SIGN_FLIP;
      host.cs_n = 1'b1;
      step(2);
      `CHK("result_out_oe_n", 1'b1, result_out_oe_n)
      $display("test rc_mode done");
   endtask : t_rc_mode

   task automatic t_cs_mode(input logic [15:0] v);
      int n;
      step(`ACQ_CYCLES);
      vin_code = v;
      host.rd_conv = 1'b0;
      step(2);
      host.cs_n = 1'b0;
      wait_busy(1'b0);
      host.cs_n = 1'b1;
      step(3);
      // a second start while busy must leave no trace
      host.cs_n = 1'b0;
      step(2);
      host.cs_n = 1'b1;
      host.rd_conv = 1'b1;
      // a taken retry would stretch busy by four more cycles
      n = 0;
      while (busy_n === 1'b0 && n < 300) begin
         n++;
         step();
      end
      // clear and load add two cycles; five have passed since the start
      `CHK("busy low after retry", `RESULT_WIDTH * `TICK_CYCLES + 2 - 5, n)
      wait_busy(1'b1);
      step(5);
      `CHK("busy_n", 1'b1, busy_n)
      host.cs_n = 1'b0;
      read_check(v ^ `SIGN_FLIP);
      pop_check(v ^ `SIGN_FLIP);
      last = v ^ `SIGN_FLIP;
      host.cs_n = 1'b1;
      step(2);
      `CHK("result_out_oe_n", 1'b1, result_out_oe_n)
      $display("test cs_mode done");
   endtask : t_cs_mode

   // both strobes held low: back-to-back conversions until the buffer refuses
   task automatic t_fifo_chain(input logic [15:0] v);
      int k;
      vin_code = v;
      host.cs_n = 1'b0;
      step(2);
      host.rd_conv = 1'b0;
      wait_busy(1'b0);
      for (k = 0; k < 16; k++) begin
         wait_busy(1'b1);
         step();
         `CHK("busy_n restart", 1'b0, busy_n)
      end
      step(150);
      `CHK("busy_n full", 1'b0, busy_n)
      host.cs_n = 1'b1;
      host.rd_conv = 1'b1;
      for (k = 0; k < 17; k++) pop_check(v ^ `SIGN_FLIP);
      step(5);
      `CHK("stream_valid", 1'b0, stream_valid)
      `CHK("busy_n", 1'b1, busy_n)
      last = v ^ `SIGN_FLIP;
      $display("test fifo_chain done");
   endtask : t_fifo_chain

   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic close_out();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out

   initial begin
      step(20);
      srst = 1'b0;
      step(2);
      t_reset();
      t_rc_mode(16'h1234, 1'b0);
      t_rc_mode(16'hfedc, 1'b1);
      t_cs_mode(16'h0000);
      t_cs_mode(16'hffff);
      t_fifo_chain(16'h00ff);
      close_out();
   end

   // whole run needs about 1400 cycles
   initial begin
      step(20000);
      fails++;
      close_out();
   end
endmodule : tb_top
